//--- src/nfc_top.sv
module nfc_top
	import nfc_pkg::*;
(
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RST_N,
	// request from the sequencer
	input  wire logic        START,
	input  nfc_req_t         REQ,
	// character and digit byte stream
	input  wire logic        IN_VALID,
	input  wire logic [7:0]  IN_BYTE,
	output logic             IN_READY,
	output logic             OUT_VALID,
	output logic      [7:0]  OUT_BYTE,
	// results
	output logic      [31:0] RESULT,
	output logic [7:0][7:0]  TEXT,
	output nfc_status_t      STATUS
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	nfc_state_t       state_ff;
	nfc_op_t          op_ff;
	logic [7:0]       rem_ff;
	logic             half_ff;
	logic [3:0]       hold_ff;
	logic             bad_acc_ff;
	logic             in_ready_ff;
	logic             out_valid_ff;
	logic [7:0]       out_byte_ff;
	logic [31:0]      result_ff;
	logic [7:0][7:0]  text_ff;
	nfc_status_t      status_ff;

	logic [31:0] fp_real;
	logic [31:0] fp_round;
	logic [31:0] fp_chop;
	logic        fp_round_ovf;
	logic        fp_chop_ovf;

	nfc_fp_unit u_fp (
		.src       (REQ.src),
		.real_val  (fp_real),
		.round_val (fp_round),
		.chop_val  (fp_chop),
		.round_ovf (fp_round_ovf),
		.chop_ovf  (fp_chop_ovf)
	);

	// ----------------------------------------------------------------
	// single-cycle conversions
	// ----------------------------------------------------------------
	logic        accept;
	logic        is_stream;
	logic [31:0] nxt_result;
	logic        ovf_touch;
	logic        ovf_hit;
	logic [8:0]  need_bytes;
	logic        range_bad;

	assign accept    = START && state_ff == ST_IDLE;
	assign is_stream = REQ.op == OP_CHAR_TO_DIGIT || REQ.op == OP_DIGIT_TO_CHAR;

	always_comb begin
		nxt_result = result_ff;
		ovf_touch  = 1'b0;
		ovf_hit    = 1'b0;
		case (REQ.op)
			OP_INT32_TO_REAL: begin
				nxt_result = fp_real;
			end
			OP_INT32_TO_INT16: begin
				ovf_touch = 1'b1;
				ovf_hit   = !((&REQ.src[31:15]) || !(|REQ.src[31:15]));
				if (!ovf_hit) begin
					nxt_result = {16'h0000, REQ.src[15:0]};
				end
			end
			OP_INT16_TO_INT32: begin
				nxt_result = {{16{REQ.src[15]}}, REQ.src[15:0]};
			end
			OP_BYTE_WIDEN: begin
				nxt_result = {24'h000000, REQ.src[7:0]};
			end
			OP_BYTE_NARROW: begin
				ovf_touch = 1'b1;
				ovf_hit   = |REQ.src[15:8];
				if (!ovf_hit) begin
					nxt_result = {24'h000000, REQ.src[7:0]};
				end
			end
			OP_REAL_ROUND: begin
				ovf_touch = 1'b1;
				ovf_hit   = fp_round_ovf;
				if (!ovf_hit) begin
					nxt_result = fp_round;
				end
			end
			OP_CHOP_FRACTION: begin
				ovf_touch = 1'b1;
				ovf_hit   = fp_chop_ovf;
				if (!ovf_hit) begin
					nxt_result = fp_chop;
				end
			end
			OP_SEVEN_SEG: begin
				nxt_result = {24'h000000, SEG_TABLE[REQ.src[3:0]]};
			end
			default: begin
				nxt_result = result_ff;
			end
		endcase
	end

	// destination bytes needed by a stream op
	always_comb begin
		if (REQ.op == OP_CHAR_TO_DIGIT) begin
			need_bytes = 9'(({1'b0, REQ.count_operand} + 9'h001) >> 1);
		end else begin
			need_bytes = {1'b0, REQ.count_operand};
		end
		range_bad = need_bytes > {1'b0, REQ.dest_span};
	end

	// ----------------------------------------------------------------
	// integer to text formatter
	// ----------------------------------------------------------------
	logic [2:0]       frac_n;
	logic             sep_on;
	logic             fmt_upper_bad;
	logic             fmt_frac_bad;
	logic             val_neg;
	logic [15:0]      val_mag;
	logic [15:0]      quot;
	// one digit beyond the five a word can hold: with five fraction digits the
	// digit next to the separator is always this zero
	logic [DEC_DIGITS:0][3:0] dig;
	logic [DEC_DIGITS:0]      shown;
	logic [3:0]       top_pos;
	logic [7:0][7:0]  fmt_text;

	always_comb begin
		frac_n        = REQ.format_byte[2:0];
		sep_on        = frac_n != 3'h0;
		fmt_upper_bad = |REQ.format_byte[7:4];
		fmt_frac_bad  = frac_n > FMT_FRAC_MAX;
		val_neg       = REQ.src[15];
		val_mag       = val_neg ? 16'(-REQ.src[15:0]) : REQ.src[15:0];
		quot          = val_mag;
		top_pos       = 4'h0;
		for (int k = 0; k <= DEC_DIGITS; k++) begin
			dig[k]   = 4'(quot % DEC_RADIX);
			shown[k] = (k <= int'(frac_n)) || (quot != 16'h0000);
			quot     = quot / DEC_RADIX;
			if (shown[k]) begin
				top_pos = 4'(k + 1) + {3'h0, sep_on};
			end
		end
	end

	// one character slot per output byte, slot 0 is the rightmost
	for (genvar p = 0; p < TEXT_BYTES; p++) begin : g_slot
		localparam int DI = p - 1;
		logic [7:0] ch;
		always_comb begin
			ch = CHAR_SPACE;
			if (sep_on && p == int'(frac_n)) begin
				ch = REQ.format_byte[FMT_SEP_BIT] ? CHAR_COMMA : CHAR_PERIOD;
			end else if (p < int'(frac_n) && p < DEC_DIGITS) begin
				ch = CHAR_NUM_LO | {4'h0, dig[p]};
			end else if (!sep_on && p < DEC_DIGITS) begin
				if (shown[p]) begin
					ch = CHAR_NUM_LO | {4'h0, dig[p]};
				end
			end else if (sep_on && DI >= 0 && DI <= DEC_DIGITS) begin
				if (shown[DI]) begin
					ch = CHAR_NUM_LO | {4'h0, dig[DI]};
				end
			end
			if (val_neg && p == int'(top_pos)) begin
				ch = CHAR_MINUS;
			end
			if (fmt_frac_bad) begin
				ch = CHAR_SPACE;
			end
		end
		assign fmt_text[TEXT_BYTES - 1 - p] = ch;
	end

	// ----------------------------------------------------------------
	// character and digit helpers
	// ----------------------------------------------------------------
	logic [3:0] in_nib;
	logic       in_bad;
	logic       take;
	logic       last_beat;

	always_comb begin
		in_bad = 1'b0;
		if (IN_BYTE >= CHAR_NUM_LO && IN_BYTE <= CHAR_NUM_HI) begin
			in_nib = IN_BYTE[3:0];
		end else if (IN_BYTE >= CHAR_ALPHA_LO && IN_BYTE <= CHAR_ALPHA_HI) begin
			in_nib = 4'(IN_BYTE - CHAR_ALPHA_OFS);
		end else begin
			in_nib = 4'h0;
			in_bad = 1'b1;
		end
	end

	function automatic logic [7:0] nib_char(input logic [3:0] n);
		nib_char = (n < NIB_TEN) ? (CHAR_NUM_LO | {4'h0, n}) : 8'({4'h0, n} + CHAR_ALPHA_OFS);
	endfunction : nib_char

	assign take      = state_ff == ST_STREAM && IN_VALID && in_ready_ff;
	assign last_beat = state_ff == ST_STREAM && rem_ff == 8'h01
		&& (take || (op_ff == OP_DIGIT_TO_CHAR && half_ff));

	// ----------------------------------------------------------------
	// stream sequencing
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_ff    <= ST_IDLE;
			op_ff       <= OP_NONE;
			rem_ff      <= 8'h00;
			half_ff     <= 1'b0;
			hold_ff     <= 4'h0;
			bad_acc_ff  <= 1'b0;
			in_ready_ff <= 1'b0;
		end else if (accept) begin
			op_ff      <= REQ.op;
			rem_ff     <= REQ.count_operand;
			half_ff    <= 1'b0;
			bad_acc_ff <= 1'b0;
			if (is_stream && !range_bad && REQ.count_operand != 8'h00) begin
				state_ff    <= ST_STREAM;
				in_ready_ff <= 1'b1;
			end
		end else if (state_ff == ST_STREAM) begin
			if (take && op_ff == OP_CHAR_TO_DIGIT) begin
				bad_acc_ff <= bad_acc_ff | in_bad;
				hold_ff    <= in_nib;
				half_ff    <= !half_ff;
			end else if (take) begin
				hold_ff     <= IN_BYTE[3:0];
				half_ff     <= rem_ff != 8'h01;
				in_ready_ff <= 1'b0;
			end else if (op_ff == OP_DIGIT_TO_CHAR && half_ff) begin
				half_ff     <= 1'b0;
				in_ready_ff <= 1'b1;
			end
			if (take || (op_ff == OP_DIGIT_TO_CHAR && half_ff)) begin
				rem_ff <= 8'(rem_ff - 8'h01);
			end
			if (last_beat) begin
				state_ff    <= ST_IDLE;
				in_ready_ff <= 1'b0;
			end
		end
	end

	// output byte stream
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			out_valid_ff <= 1'b0;
			out_byte_ff  <= 8'h00;
		end else begin
			out_valid_ff <= 1'b0;
			if (take && op_ff == OP_CHAR_TO_DIGIT) begin
				if (half_ff) begin
					out_valid_ff <= 1'b1;
					out_byte_ff  <= {hold_ff, in_nib};
				end else if (rem_ff == 8'h01) begin
					out_valid_ff <= 1'b1;
					out_byte_ff  <= {in_nib, 4'h0};
				end
			end else if (take) begin
				out_valid_ff <= 1'b1;
				out_byte_ff  <= nib_char(IN_BYTE[7:4]);
			end else if (state_ff == ST_STREAM && op_ff == OP_DIGIT_TO_CHAR && half_ff) begin
				out_valid_ff <= 1'b1;
				out_byte_ff  <= nib_char(hold_ff);
			end
		end
	end

	// ----------------------------------------------------------------
	// destinations and status
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			result_ff <= 32'h00000000;
			text_ff   <= {TEXT_BYTES{CHAR_SPACE}};
		end else if (accept && !is_stream) begin
			result_ff <= nxt_result;
			if (REQ.op == OP_INT_TEXT_FORMAT && !fmt_upper_bad) begin
				text_ff <= fmt_text;
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			status_ff <= '0;
		end else begin
			status_ff.done <= 1'b0;
			if (accept && (!is_stream || range_bad || REQ.count_operand == 8'h00)) begin
				status_ff.done       <= 1'b1;
				status_ff.range_err  <= is_stream && range_bad;
				status_ff.format_err <= REQ.op == OP_INT_TEXT_FORMAT
					&& (fmt_upper_bad || fmt_frac_bad);
				status_ff.enable_out <= !((is_stream && range_bad) || ovf_hit
					|| (REQ.op == OP_INT_TEXT_FORMAT && (fmt_upper_bad || fmt_frac_bad)));
				if (ovf_touch) begin
					status_ff.overflow_flag <= ovf_hit;
				end
				if (REQ.op == OP_CHAR_TO_DIGIT) begin
					status_ff.illegal_char_flag <= 1'b0;
				end
			end else if (last_beat) begin
				status_ff.done       <= 1'b1;
				status_ff.range_err  <= 1'b0;
				status_ff.format_err <= 1'b0;
				if (op_ff == OP_CHAR_TO_DIGIT) begin
					status_ff.illegal_char_flag <= bad_acc_ff | in_bad;
					status_ff.enable_out <= !(bad_acc_ff | in_bad);
				end else begin
					status_ff.enable_out <= 1'b1;
				end
			end
		end
	end

	assign IN_READY  = in_ready_ff;
	assign OUT_VALID = out_valid_ff;
	assign OUT_BYTE  = out_byte_ff;
	assign RESULT    = result_ff;
	assign TEXT      = text_ff;
	assign STATUS    = status_ff;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	property p_i2r_zero;
		accept && REQ.op == OP_INT32_TO_REAL && REQ.src == 32'h00000000 |=> RESULT == 32'h00000000;
	endproperty
	a_i2r_zero: assert property (p_i2r_zero) else $error("zero integer not zero real");

	property p_narrow16;
		accept && REQ.op == OP_INT32_TO_INT16 && REQ.src[31:15] == 17'h00001
		|=> STATUS.overflow_flag && !STATUS.enable_out && $stable(RESULT);
	endproperty
	a_narrow16: assert property (p_narrow16) else $error("16-bit overflow mishandled");

	property p_widen16;
		accept && REQ.op == OP_INT16_TO_INT32
		|=> RESULT == {{16{$past(REQ.src[15])}}, $past(REQ.src[15:0])};
	endproperty
	a_widen16: assert property (p_widen16) else $error("sign not extended");

	property p_byte_widen;
		accept && REQ.op == OP_BYTE_WIDEN |=> RESULT[31:8] == 24'h000000 && STATUS.enable_out;
	endproperty
	a_byte_widen: assert property (p_byte_widen) else $error("byte widening not zero filled");

	property p_byte_narrow;
		accept && REQ.op == OP_BYTE_NARROW && REQ.src[15:0] == 16'h0100
		|=> STATUS.overflow_flag && !STATUS.enable_out && $stable(RESULT)
		##1 (!STATUS.done || $past(accept));
	endproperty
	a_byte_narrow: assert property (p_byte_narrow) else $error("256 not refused");

	property p_seg;
		accept && REQ.op == OP_SEVEN_SEG
		|=> RESULT[7:0] == SEG_TABLE[$past(REQ.src[3:0])] && !RESULT[7];
	endproperty
	a_seg: assert property (p_seg) else $error("segment pattern wrong");

	property p_char_bad;
		take && op_ff == OP_CHAR_TO_DIGIT && in_bad && rem_ff == 8'h01
		|=> STATUS.done && STATUS.illegal_char_flag && !STATUS.enable_out;
	endproperty
	a_char_bad: assert property (p_char_bad) else $error("illegal char not flagged");

	property p_range;
		accept && is_stream && range_bad
		|=> STATUS.done && STATUS.range_err ##1 (!IN_READY || $past(accept));
	endproperty
	a_range: assert property (p_range) else $error("range error missing");

	property p_fmt_spaces;
		accept && REQ.op == OP_INT_TEXT_FORMAT && !fmt_upper_bad && fmt_frac_bad
		|=> TEXT == {TEXT_BYTES{CHAR_SPACE}} && STATUS.format_err;
	endproperty
	a_fmt_spaces: assert property (p_fmt_spaces) else $error("bad fraction count not blanked");

	property p_fmt_upper;
		accept && REQ.op == OP_INT_TEXT_FORMAT && fmt_upper_bad
		|=> STATUS.format_err && !STATUS.enable_out && $stable(TEXT);
	endproperty
	a_fmt_upper: assert property (p_fmt_upper) else $error("illegal format accepted");

	property p_eno;
		STATUS.done && (STATUS.range_err || STATUS.format_err) |-> !STATUS.enable_out;
	endproperty
	a_eno: assert property (p_eno) else $error("enable out high with error");

	c_stream_c2d: cover property (last_beat && op_ff == OP_CHAR_TO_DIGIT ##1 STATUS.enable_out);
	c_stream_d2c: cover property (last_beat && op_ff == OP_DIGIT_TO_CHAR);
	c_overflow:   cover property (STATUS.done && STATUS.overflow_flag);
	c_format_ok:  cover property (STATUS.done && !STATUS.format_err && TEXT[TEXT_BYTES - 1] != CHAR_SPACE);

endmodule : nfc_top

//--- src/nfc_pkg.sv
// Functional notes
// - signed 32-bit integer becomes single real
// - 32-to-16 overflow flags, destination kept
// - 16-to-32 widening copies sign bit up
// - byte widening is unsigned, zero filled
// - byte narrowing only 0..255, else overflow
// - rounding goes away from zero at half or more
// - chop keeps whole part, drops fraction
// - bad or huge real flags overflow, keeps
// - segments from low nibble, bit 7 zero
// - digits 0-9 use the fixed segment patterns
// - digits A-F use the fixed segment patterns
// - only codes 30-39, 41-46 are digits
// - convert count characters, flag illegal codes
// - digits become characters from first byte on
// - counts to 255, oversize count is range error
// - text formatter writes eight bytes, none if upper nibble bad
// - fraction count 0..5, above fills spaces, error
// - zero fraction digits means no separator
// - format bit 3 picks comma or period
// - nonzero upper format nibble is illegal
// - no plus sign, minus before first digit
// - right justified, leading integer zeros blanked
package nfc_pkg;

	// ----------------------------------------------------------------
	// operations and sequencing
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_NONE            = 4'h0,
		OP_INT32_TO_REAL   = 4'h1,
		OP_INT32_TO_INT16  = 4'h2,
		OP_INT16_TO_INT32  = 4'h3,
		OP_BYTE_WIDEN      = 4'h4,
		OP_BYTE_NARROW     = 4'h5,
		OP_REAL_ROUND      = 4'h6,
		OP_CHOP_FRACTION   = 4'h7,
		OP_SEVEN_SEG       = 4'h8,
		OP_CHAR_TO_DIGIT   = 4'h9,
		OP_DIGIT_TO_CHAR   = 4'hA,
		OP_INT_TEXT_FORMAT = 4'hB
	} nfc_op_t;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'h0,
		ST_STREAM = 2'h1
	} nfc_state_t;

	typedef struct packed {
		nfc_op_t     op;
		logic [31:0] src;
		logic [7:0]  format_byte;
		logic [7:0]  count_operand;
		logic [7:0]  dest_span;
	} nfc_req_t;

	typedef struct packed {
		logic done;
		logic enable_out;
		logic overflow_flag;
		logic illegal_char_flag;
		logic range_err;
		logic format_err;
	} nfc_status_t;

	// ----------------------------------------------------------------
	// character codes and format byte layout
	// ----------------------------------------------------------------
	localparam logic [7:0] CHAR_NUM_LO   = 8'h30;
	localparam logic [7:0] CHAR_NUM_HI   = 8'h39;
	localparam logic [7:0] CHAR_ALPHA_LO = 8'h41;
	localparam logic [7:0] CHAR_ALPHA_HI = 8'h46;
	localparam logic [7:0] CHAR_ALPHA_OFS = 8'h37;
	localparam logic [7:0] CHAR_SPACE    = 8'h20;
	localparam logic [7:0] CHAR_MINUS    = 8'h2D;
	localparam logic [7:0] CHAR_COMMA    = 8'h2C;
	localparam logic [7:0] CHAR_PERIOD   = 8'h2E;
	localparam logic [3:0] NIB_TEN       = 4'hA;
	localparam int         FMT_SEP_BIT   = 3;
	localparam logic [2:0] FMT_FRAC_MAX  = 3'h5;
	localparam int         TEXT_BYTES    = 8;
	localparam int         DEC_DIGITS    = 5;
	localparam logic [15:0] DEC_RADIX    = 16'h000A;

	// ----------------------------------------------------------------
	// segment patterns, -gfedcba, indexed by nibble
	// ----------------------------------------------------------------
	localparam logic [15:0][7:0] SEG_TABLE = {
		8'h71, 8'h79, 8'h5E, 8'h39, 8'h7C, 8'h77, 8'h67, 8'h7F,
		8'h07, 8'h7D, 8'h6D, 8'h66, 8'h4F, 8'h5B, 8'h06, 8'h3F
	};

	// ----------------------------------------------------------------
	// real number layout
	// ----------------------------------------------------------------
	localparam logic [7:0] EXP_SPECIAL = 8'hFF;
	localparam logic [7:0] EXP_INT_TOP = 8'h9E;
	localparam logic [7:0] EXP_UNIT    = 8'h96;
	localparam logic [7:0] SHIFT_LIMIT = 8'h3F;
	localparam logic [32:0] POS_LIMIT  = 33'h07FFFFFFF;
	localparam logic [32:0] NEG_LIMIT  = 33'h080000000;
	localparam logic [31:0] INT32_MIN  = 32'h80000000;

endpackage : nfc_pkg

//--- src/nfc_fp_unit.sv
module nfc_fp_unit
	import nfc_pkg::*;
(
	// operand
	input  wire logic [31:0] src,
	// results
	output logic      [31:0] real_val,
	output logic      [31:0] round_val,
	output logic      [31:0] chop_val,
	output logic             round_ovf,
	output logic             chop_ovf
);

	// ----------------------------------------------------------------
	// integer to real, round to nearest even on lost bits
	// ----------------------------------------------------------------
	logic [31:0] mag;
	logic [31:0] norm;
	logic [4:0]  lz;
	logic [24:0] mant;
	logic [7:0]  expo;
	logic        rnd_up;

	always_comb begin
		mag = src[31] ? 32'(-src) : src;
		lz  = 5'h00;
		for (int i = 0; i < 32; i++) begin
			if (mag[i]) begin
				lz = 5'(31 - i);
			end
		end
		norm   = mag << lz;
		rnd_up = norm[7] & ((|norm[6:0]) | norm[8]);
		mant   = {1'b0, norm[31:8]} + {24'h000000, rnd_up};
		expo   = 8'(EXP_INT_TOP - {3'h0, lz}) + {7'h00, mant[24]};
		if (mag == 32'h00000000) begin
			real_val = 32'h00000000;
		end else if (mant[24]) begin
			real_val = {src[31], expo, 23'h000000};
		end else begin
			real_val = {src[31], expo, mant[22:0]};
		end
	end

	// ----------------------------------------------------------------
	// real to integer: 32 fraction bits kept for the half test
	// ----------------------------------------------------------------
	logic [7:0]  e;
	logic [63:0] fix;
	logic [31:0] whole;
	logic [32:0] rmag;
	logic        neg;

	always_comb begin
		e   = src[30:23];
		neg = src[31];
		fix = {8'h00, 1'b1, src[22:0], 32'h00000000};
		if (e >= EXP_UNIT) begin
			fix = fix << 6'(e - EXP_UNIT);
		end else if (8'(EXP_UNIT - e) > SHIFT_LIMIT) begin
			fix = 64'h0000000000000000;
		end else begin
			fix = fix >> 6'(EXP_UNIT - e);
		end
		whole = fix[63:32];
		rmag  = {1'b0, whole} + {32'h00000000, fix[31]};
		round_val = neg ? 32'(-rmag) : rmag[31:0];
		chop_val  = neg ? 32'(-whole) : whole;
		round_ovf = neg ? (rmag > NEG_LIMIT) : (rmag > POS_LIMIT);
		chop_ovf  = 1'b0;
		if (e == EXP_SPECIAL) begin
			round_ovf = 1'b1;
			chop_ovf  = 1'b1;
		end else if (e >= EXP_INT_TOP) begin
			// only exactly minus two to the 31st survives
			round_ovf = !(neg && e == EXP_INT_TOP && src[22:0] == 23'h000000);
			chop_ovf  = round_ovf;
			round_val = INT32_MIN;
			chop_val  = INT32_MIN;
		end
	end

endmodule : nfc_fp_unit

//--- tb/nfc_tb.sv
module testbench;
	import nfc_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	logic              CLK = 1'b0;
	logic              RST_N = 1'b0;
	logic              START = 1'b0;
	nfc_req_t          REQ = '0;
	logic              IN_VALID = 1'b0;
	logic        [7:0] IN_BYTE = 8'h00;
	logic              IN_READY;
	logic              OUT_VALID;
	logic        [7:0] OUT_BYTE;
	logic       [31:0] RESULT;
	logic  [7:0][7:0]  TEXT;
	nfc_status_t       STATUS;
	int                err_total = 0;
	int                cmp_count = 0;
	logic        [7:0] outq[$];
	logic        [7:0] bq[$];
	logic        [7:0] seg_exp[16] = '{8'h3F, 8'h06, 8'h5B, 8'h4F, 8'h66, 8'h6D, 8'h7D, 8'h07,
		8'h7F, 8'h67, 8'h77, 8'h7C, 8'h39, 8'h5E, 8'h79, 8'h71};

	nfc_top u_dut (.CLK(CLK), .RST_N(RST_N), .START(START), .REQ(REQ), .IN_VALID(IN_VALID),
		.IN_BYTE(IN_BYTE), .IN_READY(IN_READY), .OUT_VALID(OUT_VALID), .OUT_BYTE(OUT_BYTE),
		.RESULT(RESULT), .TEXT(TEXT), .STATUS(STATUS));

	always #12.5 CLK = ~CLK;

	always @(posedge CLK) begin
		if (OUT_VALID === 1'b1) outq.push_back(OUT_BYTE);
	end

	// ----------------------------------------------------------------
	// access and compare tasks
	// ----------------------------------------------------------------
	task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic chk_flag(string nm, logic e, logic g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %b seen %b", nm, e, g);
		end
	endtask : chk_flag

	// text literals read leftmost first, the field keeps its leftmost char in byte 0
	function automatic logic [63:0] rev(logic [63:0] e);
		logic [63:0] r;
		for (int i = 0; i < 8; i++) r[8*i+:8] = e[8*(7-i)+:8];
		return r;
	endfunction : rev

	task automatic go(nfc_op_t o, logic [31:0] s, logic [7:0] f, c, sp);
		REQ = '{o, s, f, c, sp};
		START = 1'b1;
		@(posedge CLK);
		#1;
		START = 1'b0;
	endtask : go

	task automatic wait_done;
		int n;
		n = 0;
		while (STATUS.done !== 1'b1 && n < 600) begin
			@(posedge CLK);
			#1;
			n++;
		end
		chk_flag("done", 1'b1, STATUS.done);
	endtask : wait_done

	task automatic num(nfc_op_t o, logic [31:0] s, e, logic ov);
		go(o, s, 8'h00, 8'h00, 8'h00);
		wait_done;
		chk("RESULT", {32'h0, e}, {32'h0, RESULT});
		chk_flag("overflow_flag", ov, STATUS.overflow_flag);
		chk_flag("enable_out", !ov, STATUS.enable_out);
	endtask : num

	task automatic txt(logic [15:0] s, logic [7:0] f, logic [63:0] e, logic er);
		go(OP_INT_TEXT_FORMAT, {{16{s[15]}}, s}, f, 8'h00, 8'h00);
		wait_done;
		chk("TEXT", rev(e), TEXT);
		chk_flag("format_err", er, STATUS.format_err);
		chk_flag("enable_out", !er, STATUS.enable_out);
	endtask : txt

	task automatic feed(logic [7:0] b);
		int n;
		n = 0;
		IN_VALID = 1'b1;
		IN_BYTE = b;
		do begin
			@(posedge CLK);
			n++;
		end while (IN_READY !== 1'b1 && n < 50);
		#1;
	endtask : feed

	// one extra cycle so the byte that comes with done is captured too
	task automatic strm(nfc_op_t o, logic [7:0] c, sp, input logic [7:0] b[$]);
		outq.delete();
		go(o, 32'h0, 8'h00, c, sp);
		foreach (b[i]) feed(b[i]);
		IN_VALID = 1'b0;
		wait_done;
		@(posedge CLK);
		#1;
	endtask : strm

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : report_and_stop

	initial begin
		#(20000 * 25);
		err_total++;
		report_and_stop;
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge CLK);
		#1;
		RST_N = 1'b1;
		chk("RESULT", 64'h0, {32'h0, RESULT});
		chk("TEXT", {8{8'h20}}, TEXT);
		chk("STATUS", 64'h0, {58'h0, STATUS});
		$display("test reset done");
		num(OP_BYTE_WIDEN, 32'h000001FF, 32'h000000FF, 1'b0);
		num(OP_BYTE_WIDEN, 32'h00000080, 32'h00000080, 1'b0);
		num(OP_INT16_TO_INT32, 32'h00008001, 32'hFFFF8001, 1'b0);
		num(OP_INT32_TO_REAL, 32'hFFFFFFFF, 32'hBF800000, 1'b0);
		num(OP_INT32_TO_REAL, 32'h00000003, 32'h40400000, 1'b0);
		for (int i = 0; i < 16; i++) num(OP_SEVEN_SEG, {24'h0, 4'hC, 4'(i)}, {24'h0, seg_exp[i]}, 1'b0);
		num(OP_INT32_TO_INT16, 32'hFFFF8000, 32'h00008000, 1'b0);
		num(OP_INT32_TO_INT16, 32'h00012345, 32'h00008000, 1'b1);
		num(OP_BYTE_NARROW, 32'h000000FF, 32'h000000FF, 1'b0);
		num(OP_BYTE_NARROW, 32'h00000100, 32'h000000FF, 1'b1);
		num(OP_BYTE_NARROW, 32'h0000FFFF, 32'h000000FF, 1'b1);
		num(OP_REAL_ROUND, 32'h40200000, 32'h00000003, 1'b0);
		num(OP_REAL_ROUND, 32'hC0200000, 32'hFFFFFFFD, 1'b0);
		num(OP_REAL_ROUND, 32'h4019999A, 32'h00000002, 1'b0);
		num(OP_CHOP_FRACTION, 32'h40300000, 32'h00000002, 1'b0);
		num(OP_CHOP_FRACTION, 32'hC0300000, 32'hFFFFFFFE, 1'b0);
		num(OP_CHOP_FRACTION, 32'h7FC00000, 32'hFFFFFFFE, 1'b1);
		num(OP_REAL_ROUND, 32'h4F800000, 32'hFFFFFFFE, 1'b1);
		$display("test numeric done");
		txt(16'h000C, 8'h03, "   0.012", 1'b0);
		txt(16'hFF85, 8'h03, "  -0.123", 1'b0);
		txt(16'hCFC7, 8'h03, " -12.345", 1'b0);
		txt(16'h04D2, 8'h0B, "   1,234", 1'b0);
		txt(16'h3039, 8'h05, " 0.12345", 1'b0);
		txt(16'hFFFB, 8'h05, "-0.00005", 1'b0);
		txt(16'h0005, 8'h00, "       5", 1'b0);
		txt(16'h8000, 8'h00, "  -32768", 1'b0);
		txt(16'h0007, 8'h13, "  -32768", 1'b1);
		txt(16'h0007, 8'h06, "        ", 1'b1);
		$display("test text done");
		strm(OP_CHAR_TO_DIGIT, 8'h03, 8'h02, '{8'h31, 8'h41, 8'h37});
		chk("out bytes", {8'h1A, 8'h70}, {outq[0], outq[1]});
		chk_flag("illegal_char_flag", 1'b0, STATUS.illegal_char_flag);
		strm(OP_CHAR_TO_DIGIT, 8'h04, 8'h02, '{8'h46, 8'h47, 8'h39, 8'h3A});
		chk_flag("illegal_char_flag", 1'b1, STATUS.illegal_char_flag);
		chk_flag("enable_out", 1'b0, STATUS.enable_out);
		bq.delete();
		strm(OP_CHAR_TO_DIGIT, 8'h03, 8'h01, bq);
		chk("range out count", 64'h0, {32'h0, outq.size()});
		chk_flag("range_err", 1'b1, STATUS.range_err);
		chk_flag("enable_out", 1'b0, STATUS.enable_out);
		strm(OP_DIGIT_TO_CHAR, 8'h03, 8'h03, '{8'h9F, 8'h3C});
		chk("out chars", {8'h39, 8'h46, 8'h33, 8'h03}, {outq[0], outq[1], outq[2], 8'(outq.size())});
		strm(OP_DIGIT_TO_CHAR, 8'h00, 8'h00, bq);
		chk_flag("enable_out", 1'b1, STATUS.enable_out);
		for (int i = 0; i < 255; i++) bq.push_back(8'h30 + 8'(i % 10));
		strm(OP_CHAR_TO_DIGIT, 8'hFF, 8'hFF, bq);
		chk("long run", {8'h40, 8'h80}, {outq[127], 8'(outq.size())});
		$display("test stream done");
		report_and_stop;
	end

endmodule : testbench
